// File: pkg/i2c_slave_pkg.sv
// shared constants and carrier types of the two-wire slave engine
package i2c_slave_pkg;

	localparam int BYTE_BITS = 8;
	localparam logic [3:0] BIT_CNT_FULL = 4'h8;
	localparam logic [3:0] BIT_CNT_TX_LAST = 4'h7;
	localparam logic [3:0] BIT_CNT_RST = 4'h0;
	localparam logic [4:0] TEN_BIT_HDR = 5'h1E;
	localparam logic [7:0] SLAVE_ADDR_RST = 8'h00;
	localparam logic [7:0] DATA_BUF_RST = 8'h00;
	localparam logic CLK_RELEASE_RST = 1'b1;
	localparam logic [1:0] PIN_IDLE = 2'h3;

	// positions in the pin pair and in the event toggle word
	localparam int PIN_SDA = 0;
	localparam int PIN_SCL = 1;
	localparam int EV_START = 0;
	localparam int EV_STOP = 1;
	localparam int EV_RISE = 2;
	localparam int EV_FALL = 3;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RX,
		ST_HOLD,
		ST_ACK,
		ST_TX,
		ST_TXACK
	} eng_state_e;

	typedef enum logic [1:0] {
		PH_FIRST,
		PH_LOW,
		PH_DATA,
		PH_READ
	} phase_e;

	typedef struct packed {
		logic ten_bit_mode;
		logic address_hold_enable;
		logic data_hold_enable;
		logic stretch_enable;
		logic buffer_overwrite_enable;
		logic slave_collision_detect_enable;
		logic start_int_enable;
		logic ack_value_bit;
	} cfg_s;

	typedef struct packed {
		logic addr_wr;
		logic buf_wr;
		logic buf_rd;
		logic release_clk;
		logic int_clear;
		logic overflow_clear;
		logic collision_clear;
		logic [7:0] wdata;
	} cmd_s;

	typedef struct packed {
		logic [7:0] slave_address_reg;
		logic [7:0] data_buffer;
		logic buffer_full_flag;
		logic receive_overflow_flag;
		logic port_interrupt_flag;
		logic address_update_flag;
		logic clock_release_bit;
		logic ack_time_flag;
		logic received_ack_bit;
		logic bus_collision_flag;
		logic read_not_write;
		logic data_not_address;
		logic start_seen;
		logic stop_seen;
	} status_s;

	typedef struct packed {
		logic rst_m;
		logic rst_s;
		logic [1:0] pin_m;
		logic [1:0] pin_s;
		logic [1:0] pin_p;
		logic [3:0] tg;
	} link_s;

	typedef struct packed {
		logic [3:0] tg_m;
		logic [3:0] tg_s;
		logic [3:0] tg_p;
		logic [1:0] lv_m;
		logic [1:0] lv_s;
		eng_state_e st;
		phase_e ph;
		logic [3:0] cnt;
		logic [7:0] shreg;
		logic [7:0] txsr;
		logic ack_out;
		logic hold_byte;
		logic miss;
		logic prior_match;
		logic stretch;
		logic sda_drive;
		status_s stat;
	} core_s;

endpackage

// File: hw/i2c_slave_engine.sv
// two-wire slave engine: address match, receive, transmit, stretching
`timescale 1ns/10ps

// Function
// [RQ1] ten-bit high byte matches 11110 A9 A8 0
// [RQ2] high byte acked: set update flag, hold SCL
// [RQ3] low byte compared on all eight bits
// [RQ4] low mismatch still sets interrupt, update flag
// [RQ5] address write clears address update flag
// [RQ6] ten-bit read needs earlier full write match
// [RQ7] write request: clear direction, load, acknowledge
// [RQ8] full or overflow gives not-acknowledge; code acks with buffer_overwrite_enable, hold modes send ack_value_bit
// [RQ9] interrupt flag per byte, software clears
// [RQ10] stretch enable holds SCL after received bytes
// [RQ11] start sets start-seen, optional interrupt
// [RQ12] stop sets stop-seen, engine idles
// [RQ13] hold modes: interrupt, release cleared, 8th fall
// [RQ14] ack-time flag shows pre-acknowledge interrupt
// [RQ15] hold modes drive software acknowledge value
// [RQ16] hold modes: interrupt after sent acknowledge only
// [RQ17] read request: set direction, load, acknowledge
// [RQ18] after read ack clear release, hold SCL
// [RQ19] buffer write loads shifter, shift on falls
// [RQ20] master ack latched at 9th rise
// [RQ21] transmit interrupt at 9th falling edge
// [RQ22] master nack: no hold; ack: stretch
// [RQ23] transmit collision sets flag, engine idles
// [RQ24] seven-bit match ignores direction bit
// [RQ25] no hold mode: acknowledge automatically
// [RQ26] hold modes set ack-time at 8th fall
// [RQ27] restart resets slave logic like start
// [RQ28] pins synchronised, edges derived before use
module i2c_slave_engine #(
	parameter int BYTE_BITS = i2c_slave_pkg::BYTE_BITS
) (
	// system clock and control
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	// free-running link sampling clock
	input wire logic link_clk,
	// software side
	input wire i2c_slave_pkg::cfg_s cfg,
	input wire i2c_slave_pkg::cmd_s cmd,
	output i2c_slave_pkg::status_s status,
	// open-drain bus pins
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe
);

	generate
		if (BYTE_BITS != 8) begin : g_width_check
			$error("engine supports eight-bit bytes only");
		end
	endgenerate

	i2c_slave_pkg::link_s link_ff;
	i2c_slave_pkg::link_s nxt_link;
	i2c_slave_pkg::core_s core_ff;
	i2c_slave_pkg::core_s nxt_core;

	logic [3:0] ev;
	logic scl_lv;
	logic sda_lv;
	logic [7:0] rx_byte;
	logic hdr_hit;
	logic full_now;
	logic nack_now;
	logic hold_now;

	assign ev = core_ff.tg_s ^ core_ff.tg_p;
	assign scl_lv = core_ff.lv_s[i2c_slave_pkg::PIN_SCL];
	assign sda_lv = core_ff.lv_s[i2c_slave_pkg::PIN_SDA];
	assign rx_byte = core_ff.shreg;

	// link domain: pin sampling, reset sync and event toggles
	always_comb begin
		nxt_link = link_ff;
		nxt_link.rst_m = rstn;
		nxt_link.rst_s = link_ff.rst_m;
		nxt_link.pin_m = {scl_i, sda_i}; // RQ28
		nxt_link.pin_s = link_ff.pin_m; // RQ28
		nxt_link.pin_p = link_ff.pin_s;
		if (!link_ff.rst_s) begin
			nxt_link.pin_m = i2c_slave_pkg::PIN_IDLE;
			nxt_link.pin_s = i2c_slave_pkg::PIN_IDLE;
			nxt_link.pin_p = i2c_slave_pkg::PIN_IDLE;
			nxt_link.tg = '0;
		end else begin
			// start: SDA falls while SCL stays high
			if (link_ff.pin_s[1] && link_ff.pin_p[1] && link_ff.pin_p[0] &&
					!link_ff.pin_s[0]) begin
				nxt_link.tg[i2c_slave_pkg::EV_START] =
					!link_ff.tg[i2c_slave_pkg::EV_START]; // RQ28
			end
			// stop: SDA rises while SCL stays high
			if (link_ff.pin_s[1] && link_ff.pin_p[1] && !link_ff.pin_p[0] &&
					link_ff.pin_s[0]) begin
				nxt_link.tg[i2c_slave_pkg::EV_STOP] =
					!link_ff.tg[i2c_slave_pkg::EV_STOP]; // RQ28
			end
			if (link_ff.pin_s[1] && !link_ff.pin_p[1]) begin
				nxt_link.tg[i2c_slave_pkg::EV_RISE] =
					!link_ff.tg[i2c_slave_pkg::EV_RISE];
			end
			if (!link_ff.pin_s[1] && link_ff.pin_p[1]) begin
				nxt_link.tg[i2c_slave_pkg::EV_FALL] =
					!link_ff.tg[i2c_slave_pkg::EV_FALL];
			end
		end
	end

	always_ff @(posedge link_clk) begin
		link_ff <= nxt_link;
	end

	// byte decisions at the 8th falling edge
	always_comb begin
		if (cfg.ten_bit_mode) begin
			hdr_hit = rx_byte[7:1] == {i2c_slave_pkg::TEN_BIT_HDR,
				core_ff.stat.slave_address_reg[2:1]}; // RQ1
		end else begin
			hdr_hit = rx_byte[7:1] ==
				core_ff.stat.slave_address_reg[7:1]; // RQ24
		end
		full_now = core_ff.stat.buffer_full_flag ||
			core_ff.stat.receive_overflow_flag;
		nack_now = full_now && !cfg.buffer_overwrite_enable; // RQ8
		if (core_ff.ph == i2c_slave_pkg::PH_DATA) begin
			hold_now = cfg.data_hold_enable;
		end else begin
			hold_now = cfg.address_hold_enable;
		end
	end

	// system domain: the whole protocol engine
	always_comb begin
		nxt_core = core_ff;
		nxt_core.tg_m = link_ff.tg;
		nxt_core.tg_s = core_ff.tg_m;
		nxt_core.tg_p = core_ff.tg_s;
		nxt_core.lv_m = link_ff.pin_s;
		nxt_core.lv_s = core_ff.lv_m;

		// software actions first, so hardware sets win
		if (cmd.addr_wr) begin
			nxt_core.stat.slave_address_reg = cmd.wdata;
			nxt_core.stat.address_update_flag = 1'b0; // RQ5
		end
		if (cmd.buf_wr) begin
			nxt_core.stat.data_buffer = cmd.wdata;
			nxt_core.txsr = cmd.wdata; // RQ19
			nxt_core.stat.buffer_full_flag = 1'b1;
		end
		if (cmd.buf_rd) begin
			nxt_core.stat.buffer_full_flag = 1'b0;
		end
		if (cmd.release_clk) begin
			nxt_core.stat.clock_release_bit = 1'b1;
		end
		if (cmd.int_clear) begin
			nxt_core.stat.port_interrupt_flag = 1'b0; // RQ9
		end
		if (cmd.overflow_clear) begin
			nxt_core.stat.receive_overflow_flag = 1'b0;
		end
		if (cmd.collision_clear) begin
			nxt_core.stat.bus_collision_flag = 1'b0;
		end

		unique case (core_ff.st)
			i2c_slave_pkg::ST_IDLE: begin
			end
			i2c_slave_pkg::ST_RX: begin
				if (ev[i2c_slave_pkg::EV_RISE]) begin
					nxt_core.shreg = {core_ff.shreg[6:0], sda_lv};
					nxt_core.cnt = core_ff.cnt + 4'h1;
				end
				if (ev[i2c_slave_pkg::EV_FALL] &&
						core_ff.cnt == i2c_slave_pkg::BIT_CNT_FULL) begin
					nxt_core.hold_byte = 1'b0;
					nxt_core.miss = 1'b0;
					nxt_core.st = i2c_slave_pkg::ST_ACK;
					if (core_ff.ph == i2c_slave_pkg::PH_FIRST) begin
						if (cfg.ten_bit_mode && (!hdr_hit || !rx_byte[0])) begin
							nxt_core.prior_match = 1'b0;
						end
						if (!hdr_hit || (cfg.ten_bit_mode && rx_byte[0] &&
								!core_ff.prior_match)) begin // RQ6
							nxt_core.st = i2c_slave_pkg::ST_IDLE;
						end else begin
							nxt_core.stat.read_not_write = rx_byte[0]; // RQ7 RQ17
							nxt_core.stat.data_not_address = 1'b0;
						end
					end else if (core_ff.ph == i2c_slave_pkg::PH_LOW &&
							rx_byte != core_ff.stat.slave_address_reg) begin // RQ3
						nxt_core.miss = 1'b1;
					end else if (core_ff.ph == i2c_slave_pkg::PH_DATA) begin
						nxt_core.stat.data_not_address = 1'b1;
					end
					if (nxt_core.st == i2c_slave_pkg::ST_ACK && !nxt_core.miss) begin
						if (full_now) begin
							nxt_core.stat.receive_overflow_flag = 1'b1;
						end
						if (!nack_now) begin
							nxt_core.stat.data_buffer = rx_byte; // RQ7 RQ17
							nxt_core.stat.buffer_full_flag = 1'b1;
						end
						if (cfg.address_hold_enable || cfg.data_hold_enable) begin
							nxt_core.stat.ack_time_flag = 1'b1; // RQ14 RQ26
						end
						if (hold_now) begin
							nxt_core.hold_byte = 1'b1;
							nxt_core.stat.port_interrupt_flag = 1'b1; // RQ13
							nxt_core.stat.clock_release_bit = 1'b0; // RQ13
							nxt_core.st = i2c_slave_pkg::ST_HOLD;
						end else begin
							nxt_core.ack_out = nack_now; // RQ25 RQ8
						end
					end else if (nxt_core.miss) begin
						nxt_core.ack_out = 1'b1;
					end
				end
			end
			i2c_slave_pkg::ST_HOLD: begin
				// SCL is held low here until software releases it
				if (core_ff.stat.clock_release_bit) begin
					nxt_core.ack_out = cfg.ack_value_bit; // RQ15
					nxt_core.st = i2c_slave_pkg::ST_ACK;
				end
			end
			i2c_slave_pkg::ST_ACK: begin
				if (ev[i2c_slave_pkg::EV_FALL]) begin
					nxt_core.stat.ack_time_flag = 1'b0; // RQ14
					nxt_core.cnt = i2c_slave_pkg::BIT_CNT_RST;
					nxt_core.st = i2c_slave_pkg::ST_RX;
					if (core_ff.miss) begin
						nxt_core.stat.port_interrupt_flag = 1'b1; // RQ4
						nxt_core.stat.address_update_flag = 1'b1; // RQ4
						nxt_core.miss = 1'b0;
						nxt_core.st = i2c_slave_pkg::ST_IDLE;
					end else if (core_ff.ack_out) begin
						if (!core_ff.hold_byte) begin
							nxt_core.stat.port_interrupt_flag = 1'b1; // RQ9
						end
						nxt_core.st = i2c_slave_pkg::ST_IDLE; // RQ16
					end else begin
						nxt_core.stat.port_interrupt_flag = 1'b1; // RQ9 RQ16
						unique case (core_ff.ph)
							i2c_slave_pkg::PH_FIRST: begin
								if (core_ff.stat.read_not_write) begin
									nxt_core.stat.clock_release_bit = 1'b0; // RQ18
									nxt_core.ph = i2c_slave_pkg::PH_READ;
									nxt_core.st = i2c_slave_pkg::ST_TX;
								end else if (cfg.ten_bit_mode) begin
									nxt_core.stat.address_update_flag = 1'b1; // RQ2
									nxt_core.ph = i2c_slave_pkg::PH_LOW;
								end else begin
									nxt_core.ph = i2c_slave_pkg::PH_DATA;
									if (cfg.stretch_enable) begin
										nxt_core.stat.clock_release_bit = 1'b0; // RQ10
									end
								end
							end
							i2c_slave_pkg::PH_LOW: begin
								// held by the update flag, not the release bit
								nxt_core.stat.address_update_flag = 1'b1; // RQ2
								nxt_core.prior_match = 1'b1; // RQ6
								nxt_core.ph = i2c_slave_pkg::PH_DATA;
							end
							i2c_slave_pkg::PH_DATA: begin
								if (cfg.stretch_enable) begin
									nxt_core.stat.clock_release_bit = 1'b0; // RQ10
								end
							end
							i2c_slave_pkg::PH_READ: begin
								nxt_core.st = i2c_slave_pkg::ST_IDLE;
							end
						endcase
					end
				end
			end
			i2c_slave_pkg::ST_TX: begin
				if (ev[i2c_slave_pkg::EV_RISE] && core_ff.txsr[7] && !sda_lv &&
						cfg.slave_collision_detect_enable) begin
					nxt_core.stat.bus_collision_flag = 1'b1; // RQ23
					nxt_core.st = i2c_slave_pkg::ST_IDLE; // RQ23
				end else if (ev[i2c_slave_pkg::EV_FALL]) begin
					nxt_core.txsr = {core_ff.txsr[6:0], 1'b1}; // RQ19
					nxt_core.cnt = core_ff.cnt + 4'h1;
					if (core_ff.cnt == i2c_slave_pkg::BIT_CNT_TX_LAST) begin
						nxt_core.st = i2c_slave_pkg::ST_TXACK;
					end
				end
			end
			i2c_slave_pkg::ST_TXACK: begin
				if (ev[i2c_slave_pkg::EV_RISE]) begin
					nxt_core.stat.received_ack_bit = sda_lv; // RQ20
				end
				if (ev[i2c_slave_pkg::EV_FALL]) begin
					nxt_core.stat.port_interrupt_flag = 1'b1; // RQ21 RQ22
					nxt_core.cnt = i2c_slave_pkg::BIT_CNT_RST;
					if (core_ff.stat.received_ack_bit) begin
						nxt_core.st = i2c_slave_pkg::ST_IDLE; // RQ20 RQ22
					end else begin
						nxt_core.stat.clock_release_bit = 1'b0; // RQ22
						nxt_core.st = i2c_slave_pkg::ST_TX;
					end
				end
			end
			default: begin
				nxt_core.st = i2c_slave_pkg::ST_IDLE;
			end
		endcase

		// bus conditions override any byte in progress
		if (ev[i2c_slave_pkg::EV_START]) begin
			nxt_core.st = i2c_slave_pkg::ST_RX; // RQ27
			nxt_core.ph = i2c_slave_pkg::PH_FIRST; // RQ27
			nxt_core.cnt = i2c_slave_pkg::BIT_CNT_RST;
			nxt_core.miss = 1'b0;
			nxt_core.stat.ack_time_flag = 1'b0;
			nxt_core.stat.start_seen = 1'b1; // RQ11
			nxt_core.stat.stop_seen = 1'b0;
			if (cfg.start_int_enable) begin
				nxt_core.stat.port_interrupt_flag = 1'b1; // RQ11
			end
		end else if (ev[i2c_slave_pkg::EV_STOP]) begin
			nxt_core.st = i2c_slave_pkg::ST_IDLE; // RQ12
			nxt_core.prior_match = 1'b0;
			nxt_core.stat.ack_time_flag = 1'b0;
			nxt_core.stat.stop_seen = 1'b1; // RQ12
			nxt_core.stat.start_seen = 1'b0;
		end

		// grab SCL only once it is already low, never cut a high phase
		nxt_core.stretch = (!nxt_core.stat.clock_release_bit ||
			nxt_core.stat.address_update_flag) &&
			(core_ff.stretch || !scl_lv); // RQ2 RQ10 RQ18
		nxt_core.sda_drive =
			(nxt_core.st == i2c_slave_pkg::ST_ACK && !nxt_core.ack_out) ||
			(nxt_core.st == i2c_slave_pkg::ST_TX && !nxt_core.txsr[7]); // RQ19

		if (!rstn) begin
			nxt_core = '0;
			nxt_core.st = i2c_slave_pkg::ST_IDLE;
			nxt_core.ph = i2c_slave_pkg::PH_FIRST;
			nxt_core.cnt = i2c_slave_pkg::BIT_CNT_RST;
			nxt_core.stat.slave_address_reg = i2c_slave_pkg::SLAVE_ADDR_RST;
			nxt_core.stat.data_buffer = i2c_slave_pkg::DATA_BUF_RST;
			nxt_core.stat.clock_release_bit = i2c_slave_pkg::CLK_RELEASE_RST;
		end
	end

	// reset must pass even while the enable is low
	always_ff @(posedge clk) begin
		if (ce || !rstn) begin
			core_ff <= nxt_core;
		end
	end

	assign status = core_ff.stat;
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe = core_ff.stretch;
	assign sda_oe = core_ff.sda_drive;

endmodule

// File: testbench/i2c_master_model.sv
// behavioural two-wire bus master that tolerates clock stretching
`timescale 1ns/10ps
module i2c_master_model (
	// slave pull-downs
	input wire logic scl_oe,
	input wire logic sda_oe,
	// resolved wires
	output logic scl,
	output logic sda
);
	logic m_scl;
	logic m_sda;
	// pull-up on both wires: a released line reads high
	assign scl = !(m_scl | scl_oe);
	assign sda = !(m_sda | sda_oe);
	initial begin
		m_scl = 0;
		m_sda = 0;
	end
	// bounded, so a slave that never lets go cannot hang the run
	task automatic up;
		m_scl = 0;
		for (int k = 0; k < 4000 && !scl; k++)
			#100;
	endtask
	task automatic start;
		m_sda = 0;
		#1000;
		up();
		#2500;
		m_sda = 1;
		#2500;
		m_scl = 1;
		#1500;
	endtask
	task automatic stop;
		m_sda = 1;
		#1000;
		up();
		#2500;
		m_sda = 0;
		#2500;
	endtask
	// msb first; the ninth bit is the master's own answer
	task automatic byte_io(input logic [7:0] tx, input logic mack,
		output logic [7:0] rx, output logic ack);
		logic [8:0] v;
		v = {tx, mack};
		for (int i = 8; i >= 0; i--) begin
			m_sda = !v[i];
			#1000;
			up();
			#1500;
			if (i > 0)
				rx[i - 1] = sda;
			else
				ack = sda;
			#1500;
			m_scl = 1;
			#1500;
		end
	endtask
endmodule

// File: testbench/i2c_slave_engine_chk.sv
// concurrent checks on the slave engine ports
`timescale 1ns/10ps
module i2c_slave_engine_chk (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	// software side
	input wire i2c_slave_pkg::cfg_s cfg,
	input wire i2c_slave_pkg::cmd_s cmd,
	input wire i2c_slave_pkg::status_s status,
	// bus pins
	input wire logic scl_i,
	input wire logic scl_oe,
	input wire logic sda_oe
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rstn);
	a_addr_write: assert property (
		ce && cmd.addr_wr |=> status.slave_address_reg == $past(cmd.wdata)
		&& !status.address_update_flag)
		else $error("address write not taken");
	a_buf_load: assert property (
		ce && cmd.buf_wr |=> status.data_buffer == $past(cmd.wdata)
		&& status.buffer_full_flag)
		else $error("buffer write not taken");
	a_scl_when_low: assert property (
		$rose(scl_oe) |-> !$past(scl_i))
		else $error("clock pulled while high");
	a_stretch_kept: assert property (
		scl_oe && $past(scl_oe) |-> !$past(status.clock_release_bit)
		|| $past(status.address_update_flag))
		else $error("clock held after release");
	a_hold_flags: assert property (
		$rose(status.ack_time_flag) && cfg.address_hold_enable
		&& cfg.data_hold_enable |-> !status.clock_release_bit
		&& status.port_interrupt_flag)
		else $error("hold point without interrupt");
	a_acktime_mode: assert property (
		$rose(status.ack_time_flag) |-> cfg.address_hold_enable
		|| cfg.data_hold_enable)
		else $error("ack time outside hold modes");
	a_ua_ten: assert property (
		$rose(status.address_update_flag) |-> cfg.ten_bit_mode)
		else $error("update flag in seven-bit mode");
	a_ua_stretch: assert property (
		$rose(status.address_update_flag) |-> ##[0:20] scl_oe)
		else $error("update flag without stretch");
	a_bcl_enable: assert property (
		$rose(status.bus_collision_flag)
		|-> cfg.slave_collision_detect_enable)
		else $error("collision flag while disabled");
	a_stretch_cause: assert property (
		$fell(status.clock_release_bit) |-> cfg.stretch_enable
		|| status.read_not_write || cfg.address_hold_enable
		|| cfg.data_hold_enable)
		else $error("release bit cleared without cause");
endmodule
bind i2c_slave_engine i2c_slave_engine_chk chk_u (.clk(clk), .rstn(rstn),
	.ce(ce), .cfg(cfg), .cmd(cmd), .status(status), .scl_i(scl_i),
	.scl_oe(scl_oe), .sda_oe(sda_oe));

// File: testbench/testbench.sv
// self-checking bench of the two-wire slave engine
`timescale 1ns/10ps
module testbench;
	logic clk;
	logic link_clk;
	logic rstn;
	i2c_slave_pkg::cfg_s cfg;
	i2c_slave_pkg::cmd_s cmd;
	i2c_slave_pkg::status_s st;
	logic scl;
	logic sda;
	logic scl_oe;
	logic sda_oe;
	logic [7:0] rx;
	logic [7:0] adr;
	logic [7:0] dat;
	logic [7:0] hi;
	logic ack;
	int failures;
	int checks_done;
	// command strobes, in the order of the command word
	localparam logic [6:0] AW = 7'h40;
	localparam logic [6:0] BW = 7'h20;
	localparam logic [6:0] BR = 7'h10;
	localparam logic [6:0] RL = 7'h08;
	localparam logic [6:0] IC = 7'h04;
	localparam logic [6:0] OC = 7'h02;
	i2c_slave_engine dut_u (.clk(clk), .rstn(rstn), .ce(1'b1),
		.link_clk(link_clk), .cfg(cfg), .cmd(cmd), .status(st),
		.scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda),
		.sda_o(), .sda_oe(sda_oe));
	i2c_master_model bus_u (.scl_oe(scl_oe), .sda_oe(sda_oe),
		.scl(scl), .sda(sda));
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	initial begin
		link_clk = 0;
		#17;
		forever #62.5 link_clk = ~link_clk;
	end
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic sw(input logic [6:0] m, input logic [7:0] d);
		@(negedge clk);
		cmd = {m, d};
		@(negedge clk);
		cmd = '0;
	endtask
	task automatic xb(input logic [7:0] t, input logic ma);
		bus_u.byte_io(t, ma, rx, ack);
	endtask
	// software answering a held clock
	task automatic serve(input logic [6:0] m, input logic [7:0] d);
		sw(IC, 8'h00);
		sw(m, d);
		sw(RL, 8'h00);
	endtask
	function automatic logic [7:0] hdr(logic [1:0] h, logic r);
		return {5'b11110, h, r};
	endfunction
	task automatic test_done;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#5_000_000;
		failures++;
		test_done();
	end
	initial begin
		cfg = '0;
		cmd = '0;
		rstn = 0;
		failures = 0;
		checks_done = 0;
		void'($urandom(32'h4AB9B957));
		repeat (3) @(negedge clk);
		rstn = 1;
		repeat (4) @(negedge clk);
		chk("status", 32'h80, 32'(st));
		$display("test reset done");
		cfg.stretch_enable = 1;
		cfg.start_int_enable = 1;
		adr = 8'($urandom);
		sw(AW, adr | 8'h01);
		bus_u.start();
		chk("sint", 2'b11, {st.start_seen, st.port_interrupt_flag});
		xb(adr & 8'hFE, 1);
		chk("ack", 0, ack);
		chk("buf", adr & 8'hFE, st.data_buffer);
		chk("flags", 4'h5, {st.read_not_write, st.port_interrupt_flag,
			st.clock_release_bit, st.start_seen});
		serve(BR, 8'h00);
		dat = 8'($urandom);
		xb(dat, 1);
		chk("data", {2'b11, dat}, {st.data_not_address,
			st.port_interrupt_flag, st.data_buffer});
		sw(IC, 8'h00);
		sw(RL, 8'h00);
		xb(~dat, 1);
		chk("full", 2'b11, {ack, st.receive_overflow_flag});
		sw(RL, 8'h00);
		bus_u.stop();
		chk("stop", 1, st.stop_seen);
		$display("test write done");
		sw(OC, 8'h00);
		sw(BR, 8'h00);
		bus_u.start();
		xb(adr ^ 8'h80, 1);
		chk("miss", 1, ack);
		bus_u.stop();
		$display("test mismatch done");
		cfg.slave_collision_detect_enable = 1;
		bus_u.start();
		xb(adr | 8'h01, 1);
		chk("rd", 4'h5, {ack, st.read_not_write, st.clock_release_bit,
			scl_oe});
		dat = 8'($urandom);
		serve(BW, dat);
		xb(8'hFF, 0);
		chk("tx", {dat, 3'b010}, {rx, st.received_ack_bit,
			st.port_interrupt_flag, st.clock_release_bit});
		serve(BW, ~dat);
		xb(8'hFF, 1);
		chk("last", {~dat, 3'b111}, {rx, st.received_ack_bit,
			st.port_interrupt_flag, st.clock_release_bit});
		// transmit loads leave the buffer full, which would nack the header
		sw(BR, 8'h00);
		bus_u.start();
		xb(adr | 8'h01, 1);
		serve(BW, 8'hFF);
		xb(8'h7F, 1);
		chk("bcl", 2'b10, {st.bus_collision_flag, sda_oe});
		bus_u.stop();
		$display("test read done");
		cfg = '0;
		cfg.address_hold_enable = 1;
		cfg.data_hold_enable = 1;
		// software answer: nack first, then ack
		for (int n = 1; n >= 0; n--) begin
			cfg.ack_value_bit = n[0];
			sw(IC, 8'h00);
			sw(BR, 8'h00);
			bus_u.start();
			fork
				xb(adr & 8'hFE, 1);
				begin
					for (int k = 0; k < 3000 &&
							st.clock_release_bit !== 1'b0; k++)
						@(negedge clk);
					chk("hold", 2'b11, {st.ack_time_flag,
						st.port_interrupt_flag});
					serve(BR, 8'h00);
				end
			join
			chk("swack", {n[0], !n[0]},
				{ack, st.port_interrupt_flag});
			bus_u.stop();
		end
		$display("test hold done");
		cfg = '0;
		cfg.ten_bit_mode = 1;
		hi = hdr(2'($urandom), 1'b0);
		sw(AW, hi);
		bus_u.start();
		xb(hi, 1);
		chk("hi", 3'b011, {ack, st.address_update_flag, scl_oe});
		dat = 8'($urandom);
		sw(BR, 8'h00);
		sw(AW, dat);
		chk("ua", 0, st.address_update_flag);
		xb(dat, 1);
		chk("lo", 2'b01, {ack, st.address_update_flag});
		sw(BR, 8'h00);
		sw(AW, hi);
		bus_u.start();
		xb(hi | 8'h01, 1);
		chk("rd10", 2'b01, {ack, st.read_not_write});
		serve(BW, dat);
		xb(8'hFF, 1);
		bus_u.stop();
		// low byte mismatch: nack, flags set, clock held
		sw(BR, 8'h00);
		bus_u.start();
		xb(hi, 1);
		sw(BR, 8'h00);
		serve(AW, ~dat);
		xb(dat, 1);
		chk("lomiss", 5'h1D, {ack, st.address_update_flag,
			st.port_interrupt_flag, st.buffer_full_flag, scl_oe});
		sw(AW, hi);
		bus_u.stop();
		$display("test ten-bit done");
		test_done();
	end
endmodule
